// *** eeprom_cmd_map.vh ***
`ifndef EEPROM_CMD_MAP_VH
`define EEPROM_CMD_MAP_VH
// Operation codes (clocks two and three)
`define OP_SPECIAL      2'b00
`define OP_WRITE        2'b01
`define OP_READ         2'b10
`define OP_ERASE        2'b11
// Special sub-codes (first two address clocks)
`define SUB_DISABLE     2'b00
`define SUB_WRITE_ALL   2'b01
`define SUB_ERASE_ALL   2'b10
`define SUB_ENABLE      2'b11
// Word layout, erased value and frame counter sizes
`define WORD_BITS       16
`define ERASED_WORD     16'hffff
`define CNT_W           6
`define HDR_BITS        6'h03
`endif

// *** serial_eeprom_command_port.v ***
// Operation
// RULE1: Select low deselects the memory and floats the serial output.
// RULE2: Standby while deselected and idle; active once select rises.
// RULE3: Host sends instructions only after power-up and a select rise.
// RULE4: Input sampled on clock rise: start, opcode, address, data in order.
// RULE5: Serial output changes on the rising serial clock edge.
// RULE6: Every word reads all ones at first delivery.
// RULE7: Start one, opcode 10 read, 01 write, 11 erase, 00 special.
// RULE8: Write and write-all carry 16 data bits, most significant first.
// RULE9: Read shifts word out MSB first, then continues at next address.
// RULE10: Address width follows capacity, with a pad bit for 128/512.
// RULE11: Host keeps select low between commands; inputs ignored then.
// RULE12: Start bit only on high input after select rise; else dummy.
// RULE13: Write commands need enable mode; commit when select falls.
`timescale 1ns/1ps
`include "eeprom_cmd_map.vh"
module serial_eeprom_command_port #(
    parameter AW     = 6,
    parameter AFIELD = 6
) (
    // Clock and reset
    input  wire i_ref_clk,
    input  wire i_resetn,
    // Serial pins from host
    input  wire i_select,
    input  wire i_serial_clock_pin,
    input  wire i_serial_in_pin,
    // Serial output as two signals
    output reg  o_serial_out,
    output reg  o_serial_out_oe,
    // Status
    output reg  o_active,
    output reg  o_program_enabled
);
    localparam DEPTH = 1 << AW;
    // Clock counts of one frame, start bit included
    localparam integer ADDR_END_I = `HDR_BITS + AFIELD;
    localparam integer DATA_END_I = ADDR_END_I + `WORD_BITS;
    localparam [`CNT_W-1:0] ADDR_END = ADDR_END_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] DATA_END = DATA_END_I[`CNT_W-1:0];
    // Count parks one past the data count once a frame is over-clocked
    localparam [`CNT_W-1:0] OVER_END = DATA_END + 1'b1;
    localparam [`CNT_W-1:0] CNT_ONE  = {{(`CNT_W-1){1'b0}}, 1'b1};

    // Frame progress; S_DONE waits for select low to commit
    localparam S_IDLE  = 2'd0;
    localparam S_HDR   = 2'd1;
    localparam S_READ  = 2'd2;
    localparam S_DONE  = 2'd3;

    reg [`WORD_BITS-1:0] mem [0:DEPTH-1];
    reg [1:0]            state_q;
    reg                  sck_q;
    reg [`CNT_W-1:0]     cnt_q;
    reg [1:0]            op_q;
    reg [AFIELD-1:0]     afield_q;
    reg [`WORD_BITS-1:0] data_q;
    reg [`WORD_BITS-1:0] shift_q;
    reg [AW-1:0]         raddr_q;
    reg [4:0]            bit_q;
    reg                  wipe_q;
    reg [`WORD_BITS-1:0] wipe_val_q;
    reg [AW-1:0]         wipe_idx_q;

    // True for commands that carry a data word after the address
    function takes_data;
        input [1:0] op;
        input [1:0] sub_code;
        begin
            takes_data = (op == `OP_WRITE) ||
                         ((op == `OP_SPECIAL) &&
                          (sub_code == `SUB_WRITE_ALL));
        end
    endfunction

    // True for the two commands that rewrite every word
    function is_fill;
        input [1:0] op;
        input [1:0] sub_code;
        begin
            is_fill = (op == `OP_SPECIAL) &&
                      ((sub_code == `SUB_WRITE_ALL) ||
                       (sub_code == `SUB_ERASE_ALL));
        end
    endfunction

    // Edge detector resets low, matching the idle level of the clock pin
    wire sck_rise = i_serial_clock_pin & ~sck_q;
    wire [1:0] sub = afield_q[AFIELD-1 -: 2];
    // Low address bits; the pad bit for odd sizes drops out here [RULE10]
    wire [AW-1:0] addr = afield_q[AW-1:0];
    wire needs_data = takes_data(op_q, sub);
    wire fill_cmd   = is_fill(op_q, sub);
    wire [`CNT_W-1:0] need = needs_data ? DATA_END : ADDR_END;
    // Select low after exactly the expected clocks commits a frame [RULE13]
    // Short or over-clocked frames fall through without effect
    wire commit = !i_select && (state_q == S_DONE) && (cnt_q == need);
    // A fresh word is fetched at the first bit of every 16-bit slot
    wire [`WORD_BITS-1:0] read_word = (bit_q == 5'h00) ? mem[raddr_q]
                                                       : shift_q;

    // Contents are not reset; power-up state is the erased word
    integer i;
    initial begin
        for (i = 0; i < DEPTH; i = i + 1)
            mem[i] = `ERASED_WORD; // [RULE6]
    end

    always @(posedge i_ref_clk) begin
        if (wipe_q) begin
            mem[wipe_idx_q] <= wipe_val_q;
        end else if (commit && o_program_enabled) begin // [RULE13]
            if (op_q == `OP_WRITE)
                mem[addr] <= data_q; // [RULE8]
            else if (op_q == `OP_ERASE)
                mem[addr] <= `ERASED_WORD;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            state_q           <= S_IDLE;
            sck_q             <= 1'b0;
            cnt_q             <= {`CNT_W{1'b0}};
            op_q              <= 2'b00;
            afield_q          <= {AFIELD{1'b0}};
            data_q            <= {`WORD_BITS{1'b0}};
            shift_q           <= {`WORD_BITS{1'b0}};
            raddr_q           <= {AW{1'b0}};
            bit_q             <= 5'h00;
            wipe_q            <= 1'b0;
            wipe_val_q        <= {`WORD_BITS{1'b0}};
            wipe_idx_q        <= {AW{1'b0}};
            o_serial_out      <= 1'b0;
            o_serial_out_oe   <= 1'b0;
            o_active          <= 1'b0;
            o_program_enabled <= 1'b0;
        end else begin
            sck_q    <= i_serial_clock_pin;
            // A running fill keeps the part active after deselect
            o_active <= i_select | wipe_q; // [RULE2]
            // Fill runs one word per clock; serial rises are ignored until it ends
            if (wipe_q) begin
                wipe_idx_q <= wipe_idx_q + 1'b1;
                if (wipe_idx_q == DEPTH - 1)
                    wipe_q <= 1'b0;
            end
            if (!i_select) begin
                // Pins ignored while deselected [RULE11]
                o_serial_out_oe <= 1'b0; // [RULE1]
                o_serial_out    <= 1'b0;
                state_q         <= S_IDLE;
                // Commit only if the exact clock count was given [RULE13]
                // Enable mode survives deselect; only disable or reset drop it
                if (commit && op_q == `OP_SPECIAL) begin
                    case (sub)
                        `SUB_ENABLE:  o_program_enabled <= 1'b1;
                        `SUB_DISABLE: o_program_enabled <= 1'b0;
                        `SUB_WRITE_ALL, `SUB_ERASE_ALL: begin
                            if (fill_cmd && o_program_enabled && !wipe_q) begin
                                wipe_q     <= 1'b1;
                                wipe_idx_q <= {AW{1'b0}};
                                wipe_val_q <= (sub == `SUB_WRITE_ALL) ?
                                              data_q : `ERASED_WORD;
                            end
                        end
                        default: ;
                    endcase
                end
            end else if (sck_rise && !wipe_q) begin // [RULE4] [RULE5]
                case (state_q)
                    S_IDLE: begin
                        if (i_serial_in_pin) begin // [RULE12] [RULE3]
                            state_q <= S_HDR;
                            cnt_q   <= CNT_ONE;
                        end
                    end
                    S_HDR: begin
                        cnt_q <= cnt_q + 1'b1;
                        if (cnt_q < `HDR_BITS)
                            op_q <= {op_q[0], i_serial_in_pin}; // [RULE7]
                        else
                            afield_q <= {afield_q[AFIELD-2:0],
                                         i_serial_in_pin};
                        if (cnt_q == ADDR_END - 1'b1) begin
                            if (op_q == `OP_READ) begin
                                // Dummy low bit before data [RULE9]
                                state_q         <= S_READ;
                                raddr_q         <= {afield_q[AW-2:0],
                                                    i_serial_in_pin};
                                o_serial_out_oe <= 1'b1;
                                o_serial_out    <= 1'b0;
                                bit_q           <= 5'h00;
                            end else begin
                                state_q <= S_DONE;
                            end
                        end
                    end
                    S_READ: begin
                        // Bit index counts down from the MSB [RULE9]
                        shift_q      <= read_word;
                        o_serial_out <= read_word[`WORD_BITS-1 - bit_q];
                        if (bit_q == `WORD_BITS - 1) begin
                            bit_q   <= 5'h00;
                            raddr_q <= raddr_q + 1'b1; // [RULE9]
                        end else begin
                            bit_q <= bit_q + 1'b1;
                        end
                    end
                    S_DONE: begin
                        // Extra clocks past the count cancel the command
                        if (cnt_q != OVER_END)
                            cnt_q <= cnt_q + 1'b1;
                        if (needs_data && cnt_q < DATA_END)
                            data_q <= {data_q[`WORD_BITS-2:0],
                                       i_serial_in_pin}; // [RULE8]
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end
endmodule

// *** port_chk_chk.sv ***
`timescale 1ns/1ps
module port_chk #(parameter AFIELD = 6) (
    input wire i_ref_clk,
    input wire i_resetn,
    input wire i_select,
    input wire i_serial_clock_pin,
    input wire i_serial_in_pin,
    input wire o_serial_out,
    input wire o_serial_out_oe,
    input wire o_active,
    input wire o_program_enabled
);
    reg       sck_q;
    reg [4:0] rises_q;
    wire      rise = i_select & i_serial_clock_pin & ~sck_q;
    // Dummy clocks are counted too, so the bound is a floor only
    always @(posedge i_ref_clk) begin
        sck_q   <= i_serial_clock_pin;
        rises_q <= i_select ? rises_q + {4'h0, rise & ~&rises_q} : 5'h0;
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    sequence oe_up; $rose(o_serial_out_oe); endsequence
    sequence sk_rose; $past(rise) || $past(rise, 2); endsequence
    oe_off_a: assert property (!i_select |=> !o_serial_out_oe)
        else $error("output driven while deselected");
    active_sel_a: assert property (i_select |=> o_active)
        else $error("not active while selected");
    standby_a: assert property ($fell(o_active) |-> !$past(i_select))
        else $error("left active state while selected");
    out_step_a: assert property (o_serial_out_oe &&
        $past(o_serial_out_oe) && $changed(o_serial_out) |-> sk_rose)
        else $error("output changed without a serial clock rise");
    oe_hold_a: assert property (o_serial_out_oe && i_select |=>
        o_serial_out_oe)
        else $error("read output dropped while selected");
    first_low_a: assert property (oe_up |-> !o_serial_out)
        else $error("read output not low before first bit");
    oe_after_rise_a: assert property (oe_up |-> sk_rose)
        else $error("output enabled without a serial clock rise");
    oe_count_a: assert property (oe_up |-> rises_q >= AFIELD + 3)
        else $error("output enabled before address complete");
endmodule

// *** host_model.sv ***
`timescale 1ns/1ps
module host_model (
    input  wire        i_ref_clk,
    input  wire        i_so,
    output reg         o_sel,
    output reg         o_sck,
    output reg         o_sdi,
    output reg  [31:0] o_word
);
    initial begin
        o_sel = 1'b0;
        o_sck = 1'b0;
        o_sdi = 1'b0;
        o_word = 32'h0000_0000;
    end
    // Low phase lasts two ref cycles and high phase four so the edge detector sees each
    task clk_bit(input b);
        begin
            @(posedge i_ref_clk);
            o_sck <= 1'b0;
            o_sdi <= b;
            repeat (2) @(posedge i_ref_clk);
            o_sck <= 1'b1;
            repeat (3) @(posedge i_ref_clk);
            o_word = {o_word[30:0], i_so};
        end
    endtask
    task frame(input integer n, input [31:0] v, input integer rd);
        integer i;
        begin
            @(posedge i_ref_clk);
            o_sel <= 1'b1;
            repeat (2) clk_bit(1'b0);
            for (i = n - 1; i >= 0; i = i - 1) clk_bit(v[i]);
            repeat (rd) clk_bit(1'b0);
            @(posedge i_ref_clk);
            o_sel <= 1'b0;
            o_sck <= 1'b0;
            repeat (80) @(posedge i_ref_clk);
        end
    endtask
endmodule

// *** test_serial_eeprom_command_port.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks = total_checks + 1; if ((a) !== (b)) \
begin failures = failures + 1; \
$display("wrong value at %0t: %h expected %h", $time, a, b); end end
module test_serial_eeprom_command_port;
    reg         i_ref_clk = 1'b0;
    reg         i_resetn = 1'b0;
    wire        sel, sck, sdi, so, oe, act, pen;
    wire [31:0] rd;
    integer     failures = 0, total_checks = 0, cyc = 0, a;
    reg  [15:0] mem [0:63];
    reg  [15:0] d;
    reg         en = 1'b0;
    serial_eeprom_command_port #(.AW(6), .AFIELD(6)) dut (
        .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_select(sel),
        .i_serial_clock_pin(sck), .i_serial_in_pin(sdi),
        .o_serial_out(so), .o_serial_out_oe(oe), .o_active(act),
        .o_program_enabled(pen));
    host_model host (.i_ref_clk(i_ref_clk), .i_so(so), .o_sel(sel),
        .o_sck(sck), .o_sdi(sdi), .o_word(rd));
    initial forever #10 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cyc = cyc + 1;
        if (cyc > 20000) begin
            failures = failures + 1;
            end_of_test;
        end
    end
    task end_of_test;
        begin
            $display("checks %0d failures %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    task rd_chk(input [5:0] ad);
        begin
            host.frame(9, {23'h0, 3'b110, ad}, 32);
            `CHK(rd, {mem[ad], mem[ad + 6'h01]})
        end
    endtask
    task run(input [1:0] op, input [5:0] ad, input [15:0] dat);
        integer i;
        begin
            if (op == 2'b01 || (op == 2'b00 && ad[5:4] == 2'b01))
                host.frame(25, {7'h0, 1'b1, op, ad, dat}, 0);
            else host.frame(9, {23'h0, 1'b1, op, ad}, 0);
            if (op == 2'b00 && ad[5:4] == 2'b11) en = 1'b1;
            if (op == 2'b00 && ad[5:4] == 2'b00) en = 1'b0;
            for (i = 0; i < 64; i = i + 1)
                if (en && ((op == 2'b00 && ad[5] != ad[4]) || (op[0] && i == ad)))
                    mem[i] = (op == 2'b11 || (op == 2'b00 && ad[5:4] == 2'b10))
                        ? 16'hffff : dat;
            `CHK(pen, en)
        end
    endtask
    initial begin
        a = $urandom(32'hd8f8);
        for (a = 0; a < 64; a = a + 1) mem[a] = 16'hffff;
        repeat (3) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        @(posedge i_ref_clk);
        `CHK({oe, act, pen}, 3'h0)
        rd_chk(6'h05);
        d = $urandom;
        run(2'b01, 6'h05, d);
        rd_chk(6'h05);
        run(2'b00, 6'h30, 16'h0000);
        d = $urandom;
        host.frame(25, {7'h0, 1'b1, 2'b01, 6'h05, d}, 1);
        rd_chk(6'h05);
        d = $urandom;
        run(2'b01, 6'h3f, d);
        rd_chk(6'h3f);
        run(2'b11, 6'h3f, 16'h0000);
        rd_chk(6'h3e);
        d = $urandom;
        run(2'b00, 6'h10, d);
        rd_chk(6'h09);
        run(2'b00, 6'h20, 16'h0000);
        rd_chk(6'h09);
        a = $urandom % 63;
        d = $urandom;
        run(2'b01, a[5:0], d);
        rd_chk(a[5:0]);
        run(2'b00, 6'h00, 16'h0000);
        run(2'b11, a[5:0], 16'h0000);
        rd_chk(a[5:0]);
        end_of_test;
    end
endmodule
bind serial_eeprom_command_port port_chk #(.AFIELD(AFIELD)) chk (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_select(i_select),
    .i_serial_clock_pin(i_serial_clock_pin),
    .i_serial_in_pin(i_serial_in_pin), .o_serial_out(o_serial_out),
    .o_serial_out_oe(o_serial_out_oe), .o_active(o_active),
    .o_program_enabled(o_program_enabled));
